/* File: shared/bodc_pkg.sv */
`default_nettype none

package bodc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned MOTOR_IDLE_S   = 15;           // Motor inactivity time, seconds
  localparam logic [31:0] MOTOR_IDLE_CYC = 32'(64'(MOTOR_IDLE_S) * 64'(CLK_HZ));
  localparam int unsigned FDC_CLK_PER_BIT = 16;          // Controller clock per MFM bit

  // MFM data rates in bits per second, indexed by the two rate bits
  localparam int unsigned RATE_BPS_0 = 500_000;
  localparam int unsigned RATE_BPS_1 = 250_000;
  localparam int unsigned RATE_BPS_2 = 300_000;
  localparam int unsigned RATE_BPS_3 = 150_000;

  // ----------------------------------------------------------------------
  // Relative I/O ports
  // ----------------------------------------------------------------------
  localparam logic [1:0] PORT_SEL_STAT = 2'h0;  // Read status, write drive select
  localparam logic [1:0] PORT_DATA     = 2'h1;  // Controller data, both ways
  localparam logic [1:0] PORT_DRV_DMA  = 2'h2;  // Read drive status, write DMA address
  localparam logic [1:0] PORT_MOTOR    = 2'h3;  // Write motor control

  // ----------------------------------------------------------------------
  // Drive select register fields and reset value
  // ----------------------------------------------------------------------
  localparam int unsigned DSEL_HDLD_BIT   = 2;
  localparam int unsigned DSEL_F2S_BIT    = 3;
  localparam int unsigned DSEL_RWRITE_BIT = 4;
  localparam int unsigned DSEL_RATE_LSB   = 5;
  localparam int unsigned DSEL_FDCRST_BIT = 7;
  localparam logic [7:0]  DSEL_RESET      = 8'h14;  // Head load and reduced write idle high

  // ----------------------------------------------------------------------
  // Motor control register fields
  // ----------------------------------------------------------------------
  localparam int unsigned MOTOR_ON_BIT    = 0;
  localparam int unsigned BOOT_OFF_BIT    = 7;

  // ----------------------------------------------------------------------
  // Drive status register fields and board switch
  // ----------------------------------------------------------------------
  localparam int unsigned DSTAT_READY_BIT = 0;
  localparam int unsigned DSTAT_INDEX_BIT = 1;
  localparam int unsigned DSTAT_SW_BIT    = 2;
  localparam int unsigned DSTAT_INT_BIT   = 7;
  localparam int unsigned SW_BOOT_IDX     = 8;   // Switch position 9
  localparam int unsigned SW_READ_IDX     = 9;   // Switch position 10, readable

  typedef enum logic [1:0] {
    BODC_IDLE,
    BODC_ANSWER
  } bodc_phase_e;

endpackage : bodc_pkg

`default_nettype wire

/* File: rtl/bodc_rate_gen.sv */
`timescale 1ns/1ns
`default_nettype none

// Fractional divider: emits a one-cycle enable at 16x the chosen MFM rate
module bodc_rate_gen
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // Rate choice
  input  wire logic [1:0] rate_sel_in,
  // Controller clock enable
  output logic            fdc_clk_en_out
);

  logic [31:0] acc;
  logic [31:0] step;
  logic [32:0] sum;

  // --------------------------------------------------------------------
  // Step size per rate
  // --------------------------------------------------------------------
  // Step is the controller clock in Hz, so the average pulse rate is exact
  always_comb
  begin
    unique case (rate_sel_in)
      2'h0: step = 32'(bodc_pkg::RATE_BPS_0 * bodc_pkg::FDC_CLK_PER_BIT);
      2'h1: step = 32'(bodc_pkg::RATE_BPS_1 * bodc_pkg::FDC_CLK_PER_BIT);
      2'h2: step = 32'(bodc_pkg::RATE_BPS_2 * bodc_pkg::FDC_CLK_PER_BIT);
      2'h3: step = 32'(bodc_pkg::RATE_BPS_3 * bodc_pkg::FDC_CLK_PER_BIT);
    endcase
  end

  assign sum = {1'b0, acc} + {1'b0, step};

  // Phase accumulator wraps at the board clock rate
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      acc            <= 32'h0;
      fdc_clk_en_out <= 1'b0;
    end
    else if (sum >= 33'(bodc_pkg::CLK_HZ))
    begin
      acc            <= 32'(sum - 33'(bodc_pkg::CLK_HZ));
      fdc_clk_en_out <= 1'b1;
    end
    else
    begin
      acc            <= sum[31:0];
      fdc_clk_en_out <= 1'b0;
    end
  end

endmodule : bodc_rate_gen

`default_nettype wire

/* File: rtl/bodc_top.sv */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Switch on: boot ROM answers every memory address
// - Overlay active: phantom and ROM data on reads
// - No phantom on memory writes or I/O cycles
// - Motor register bit 7 one latches overlay off
// - Rate bits change controller clock frequency
// - Motors switch off after 15 idle seconds
// - Jumpered drive reads ready whenever selected
// - Force bit presents two-sided to controller
// - Any card access restarts motor timer
// - Drive select bits 6:5 choose data rate
module bodc_top
#(
  parameter logic [31:0] MOTOR_IDLE_CYCLES = bodc_pkg::MOTOR_IDLE_CYC,
  parameter int unsigned ROM_AW            = 11,
  parameter int unsigned DRIVES            = 4
)
(
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // Host bus cycle strobes, one cycle each
  input  wire logic              host_mem_rd_in,
  input  wire logic              host_mem_wr_in,
  input  wire logic              host_io_rd_in,
  input  wire logic              host_io_wr_in,
  input  wire logic [15:0]       host_addr_in,
  input  wire logic [7:0]        host_wdata_in,
  // Host bus answer
  output logic                   phantom_n_out,
  output logic [7:0]             host_rdata_out,
  output logic                   host_rdata_oe_n_out,
  // Board straps
  input  wire logic [9:0]        board_config_switch_in,
  input  wire logic [5:0]        port_base_in,
  input  wire logic [DRIVES-1:0] ready_substitute_jumpers_in,
  // Boot ROM
  output logic [ROM_AW-1:0]      rom_addr_out,
  input  wire logic [7:0]        rom_data_in,
  // Floppy controller side
  input  wire logic [7:0]        fdc_status_in,
  input  wire logic [7:0]        fdc_rdata_in,
  input  wire logic              fdc_int_in,
  input  wire logic [1:0]        fdc_unit_in,
  output logic                   fdc_rd_out,
  output logic                   fdc_wr_out,
  output logic                   fdc_status_rd_out,
  output logic [7:0]             fdc_wdata_out,
  output logic                   fdc_reset_out,
  output logic                   fdc_clk_en_out,
  output logic                   fdc_ready_out,
  output logic                   fdc_two_sided_out,
  // Drive side
  input  wire logic              drive_ready_in,
  input  wire logic              drive_index_in,
  input  wire logic              drive_two_sided_in,
  output logic                   motor_on_out,
  output logic                   head_load_n_out,
  output logic                   reduced_write_n_out,
  output logic                   force_double_side_out
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic       io_hit;
  logic       io_rd;
  logic       io_wr;
  logic [1:0] port;
  logic       overlay_en;
  logic       boot_sw;
  logic       strap_pending;
  logic       rom_rd;
  logic       access;
  logic [7:0] dsel;
  logic [31:0] idle_cnt;
  logic [7:0] next_rdata;
  logic       drive_status_ready;
  bodc_pkg::bodc_phase_e phase;

  // Card answers on its four-port block; only bits 7:2 are decoded, so it repeats every 256 ports
  assign io_hit = (host_addr_in[7:2] == port_base_in);
  assign io_rd  = host_io_rd_in & io_hit;
  assign io_wr  = host_io_wr_in & io_hit;
  assign port   = host_addr_in[1:0];

  // every address decoded: the ROM ignores upper address bits
  assign rom_addr_out = host_addr_in[ROM_AW-1:0];
  // reads only: writes and I/O never claim the overlay
  assign rom_rd = host_mem_rd_in & overlay_en & boot_sw;

  // Any touch of the card, ROM reads included, counts as activity
  assign access = io_rd | io_wr | rom_rd;

  // ----------------------------------------------------------------------
  // Boot overlay latch
  // ----------------------------------------------------------------------
  // overlay latch: reset sets it, only the disable write clears it
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      overlay_en <= 1'b1;
    // one-shot disable, later writes cannot re-arm it
    else if (io_wr && port == bodc_pkg::PORT_MOTOR &&
             host_wdata_in[bodc_pkg::BOOT_OFF_BIT])
      overlay_en <= 1'b0;
  end

  // Switch is caught on the first edge after reset release, so the overlay
  // is dark for that single cycle; no host cycle should land there anyway
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      strap_pending <= 1'b1;
      boot_sw       <= 1'b0;
    end
    else if (strap_pending)
    begin
      strap_pending <= 1'b0;
      boot_sw       <= board_config_switch_in[bodc_pkg::SW_BOOT_IDX];
    end
  end

  // ----------------------------------------------------------------------
  // Drive select register
  // ----------------------------------------------------------------------
  // rate bits and the other select controls held here
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      dsel <= bodc_pkg::DSEL_RESET;
    else if (io_wr && port == bodc_pkg::PORT_SEL_STAT)
      dsel <= host_wdata_in;
  end

  // Controller reset follows system reset as well as the software bit
  assign fdc_reset_out         = reset_in | dsel[bodc_pkg::DSEL_FDCRST_BIT];
  assign head_load_n_out       = dsel[bodc_pkg::DSEL_HDLD_BIT];
  assign reduced_write_n_out   = dsel[bodc_pkg::DSEL_RWRITE_BIT];
  assign force_double_side_out = dsel[bodc_pkg::DSEL_F2S_BIT];

  // two-sided indication forced for double-sided minifloppies
  assign fdc_two_sided_out = drive_two_sided_in | dsel[bodc_pkg::DSEL_F2S_BIT];

  // jumpered position reads ready while it is selected
  assign drive_status_ready = drive_ready_in |
                              ready_substitute_jumpers_in[fdc_unit_in];
  assign fdc_ready_out      = drive_status_ready;

  // ----------------------------------------------------------------------
  // Controller clock
  // ----------------------------------------------------------------------
  // rate bits steer the controller clock divider
  bodc_rate_gen i_bodc_rate_gen
  (
    .clock_in       (clock_in),
    .reset_in       (reset_in),
    .rate_sel_in    (dsel[bodc_pkg::DSEL_RATE_LSB +: 2]),
    .fdc_clk_en_out (fdc_clk_en_out)
  );

  // ----------------------------------------------------------------------
  // Motor control and inactivity timeout
  // ----------------------------------------------------------------------
  // access restarts the idle count
  always_ff @(posedge clock_in)
  begin
    if (reset_in || access)
      idle_cnt <= 32'h0;
    else if (idle_cnt != MOTOR_IDLE_CYCLES)
      idle_cnt <= idle_cnt + 32'h1;
  end

  // Any access wins over the timeout, since the drop is gated off by access in that cycle
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      motor_on_out <= 1'b0;
    else if (io_wr && port == bodc_pkg::PORT_MOTOR)
      motor_on_out <= host_wdata_in[bodc_pkg::MOTOR_ON_BIT];
    // idle timeout drops the single motor_on_out line
    else if (!access && idle_cnt == MOTOR_IDLE_CYCLES - 32'h1)
      motor_on_out <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Controller access strobes
  // ----------------------------------------------------------------------
  // Strobes are combinational so the controller sees the same cycle
  assign fdc_rd_out        = io_rd & (port == bodc_pkg::PORT_DATA);
  assign fdc_status_rd_out = io_rd & (port == bodc_pkg::PORT_SEL_STAT);
  assign fdc_wr_out        = io_wr & (port == bodc_pkg::PORT_DATA);
  assign fdc_wdata_out     = host_wdata_in;

  // ----------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------
  // DMA address writes are accepted but the DMA engine lives elsewhere
  always_comb
  begin
    next_rdata = 8'h00;
    if (rom_rd)
      next_rdata = rom_data_in;
    else if (io_rd)
    begin
      unique case (port)
        bodc_pkg::PORT_SEL_STAT: next_rdata = fdc_status_in;
        bodc_pkg::PORT_DATA:     next_rdata = fdc_rdata_in;
        bodc_pkg::PORT_DRV_DMA:
        begin
          next_rdata[bodc_pkg::DSTAT_READY_BIT] = drive_status_ready;
          next_rdata[bodc_pkg::DSTAT_INDEX_BIT] = drive_index_in;
          next_rdata[bodc_pkg::DSTAT_SW_BIT]    =
            ~board_config_switch_in[bodc_pkg::SW_READ_IDX];
          next_rdata[bodc_pkg::DSTAT_INT_BIT]   = fdc_int_in;
        end
        bodc_pkg::PORT_MOTOR:    next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
      phase <= bodc_pkg::BODC_IDLE;
    else if (rom_rd || io_rd)
      phase <= bodc_pkg::BODC_ANSWER;
    else
      phase <= bodc_pkg::BODC_IDLE;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      host_rdata_out <= 8'h00;
      phantom_n_out  <= 1'b1;
    end
    else
    begin
      host_rdata_out <= next_rdata;
      // phantom with ROM data on each overlay read
      phantom_n_out  <= ~rom_rd;
    end
  end

  // Driver enable is low while the card drives read data
  assign host_rdata_oe_n_out = (phase != bodc_pkg::BODC_ANSWER);

endmodule : bodc_top

`default_nettype wire

/* File: testbench/bodc_chk.sv */
`timescale 1ns/1ns
`default_nettype none

// Watches the host answer, the motor timer and the drive lines
module bodc_chk
#(
  parameter logic [31:0] MOTOR_IDLE_CYCLES = bodc_pkg::MOTOR_IDLE_CYC,
  parameter int unsigned DRIVES            = 4
)
(
  // Clock and reset
  input wire logic              clock_in,
  input wire logic              reset_in,
  // Host bus
  input wire logic              host_mem_rd_in,
  input wire logic              host_io_rd_in,
  input wire logic              host_io_wr_in,
  input wire logic [15:0]       host_addr_in,
  input wire logic [7:0]        host_wdata_in,
  input wire logic              phantom_n_out,
  input wire logic [7:0]        host_rdata_out,
  input wire logic              host_rdata_oe_n_out,
  // Straps and ROM
  input wire logic [9:0]        board_config_switch_in,
  input wire logic [5:0]        port_base_in,
  input wire logic [DRIVES-1:0] ready_substitute_jumpers_in,
  input wire logic [7:0]        rom_data_in,
  // Drive side
  input wire logic [1:0]        fdc_unit_in,
  input wire logic              fdc_ready_out,
  input wire logic              fdc_two_sided_out,
  input wire logic              motor_on_out,
  input wire logic              force_double_side_out,
  // Controller strobes
  input wire logic              fdc_rd_out,
  input wire logic              fdc_wr_out,
  input wire logic              fdc_status_rd_out,
  input wire logic [7:0]        fdc_wdata_out
);
  logic        ovl;
  logic        card;
  logic        claim;
  logic        m_wr;
  logic        s_wr;
  logic [31:0] idle;
  logic        p0;
  logic        p1;

  // Decode of the cycles that touch the card
  assign card  = (host_io_rd_in | host_io_wr_in) & (host_addr_in[7:2] == port_base_in);
  assign claim = host_mem_rd_in & ovl & board_config_switch_in[8];
  assign m_wr  = card & host_io_wr_in & (host_addr_in[1:0] == 2'h3);
  assign s_wr  = card & host_io_wr_in & (host_addr_in[1:0] == 2'h0);
  assign p0    = (host_addr_in[1:0] == 2'h0);
  assign p1    = (host_addr_in[1:0] == 2'h1);

  // Overlay shadow; only a reset brings it back
  always_ff @(posedge clock_in)
    if (reset_in | (m_wr & host_wdata_in[7]))
      ovl <= reset_in;

  // Cycles since the last access; saturates so it never wraps to a false restart
  always_ff @(posedge clock_in)
    if (reset_in | card | claim)
      idle <= 32'h0;
    else if (idle != 32'hffffffff)
      idle <= idle + 32'h1;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_answer;
    !phantom_n_out && !host_rdata_oe_n_out;
  endsequence
  sequence s_quiet;
    phantom_n_out && host_rdata_oe_n_out;
  endsequence

  a_phantom_on_read: assert property (claim |=> s_answer)
    else $error("claimed read got no phantom");
  a_rom_data_out: assert property (claim |=> host_rdata_out == $past(rom_data_in))
    else $error("read data differs from ROM byte");
  a_no_phantom: assert property (!host_mem_rd_in |=> phantom_n_out)
    else $error("phantom without a memory read");
  a_unclaimed_quiet: assert property (host_mem_rd_in && !claim |=> s_quiet)
    else $error("unclaimed read was answered");
  a_motor_hold: assert property (motor_on_out && !m_wr &&
    (card || claim || idle < MOTOR_IDLE_CYCLES - 32'd1) |=> motor_on_out)
    else $error("motor dropped before timeout");
  a_motor_timeout: assert property (idle >= MOTOR_IDLE_CYCLES |-> !motor_on_out)
    else $error("motor still on after timeout");
  a_ready_subst: assert property (ready_substitute_jumpers_in[fdc_unit_in] |-> fdc_ready_out)
    else $error("jumpered drive not ready");
  a_two_sided: assert property (force_double_side_out |-> fdc_two_sided_out)
    else $error("force bit not shown as two-sided");
  a_force_set: assert property (s_wr |=> force_double_side_out == $past(host_wdata_in[3]))
    else $error("force bit not taken from write");
  a_ctrl_strobes: assert property ({fdc_rd_out, fdc_wr_out, fdc_status_rd_out} ==
    {card & host_io_rd_in & p1, card & host_io_wr_in & p1, card & host_io_rd_in & p0})
    else $error("controller strobe mismatch");
  a_ctrl_wdata: assert property (fdc_wr_out |-> fdc_wdata_out == host_wdata_in)
    else $error("controller write data differs");
endmodule : bodc_chk

`default_nettype wire

/* File: testbench/bodc_host.sv */
`timescale 1ns/1ns
`default_nettype none

// Host processor model: one bus cycle at a time, driven 1 ns after an edge
module bodc_host
#(
  parameter int unsigned SPIN_CYCLES   = 20,   // Shortened spin-up, real drives need far longer
  parameter int unsigned SETTLE_CYCLES = 1250  // 5 us at 4 ns
)
(
  // Clock and card answer
  input  wire logic       clock_in,
  input  wire logic [5:0] base_in,
  input  wire logic       phantom_n_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rdata_oe_n_in,
  // Bus cycle
  output logic            mem_rd_out,
  output logic            mem_wr_out,
  output logic            io_rd_out,
  output logic            io_wr_out,
  output logic [15:0]     addr_out,
  output logic [7:0]      wdata_out
);
  logic [7:0] rd;
  logic       ph;
  logic       oe_n;

  // Bus idle at time zero
  initial
  begin
    {mem_rd_out, mem_wr_out, io_rd_out, io_wr_out} = 4'h0;
    addr_out  = 16'h0;
    wdata_out = 8'h0;
  end

  // Kind 0 memory read, 1 memory write, 2 I/O read, 3 I/O write
  task automatic cycle(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in) #1;
    addr_out  = a;
    wdata_out = d;
    {mem_rd_out, mem_wr_out, io_rd_out, io_wr_out} = 4'b1000 >> kind;
    @(posedge clock_in) #1;
    {mem_rd_out, mem_wr_out, io_rd_out, io_wr_out} = 4'h0;
    // Released lines show the inverse, never the stale value
    addr_out  = ~a;
    wdata_out = ~d;
    rd        = rdata_in;
    ph        = phantom_n_in;
    oe_n      = rdata_oe_n_in;
  endtask : cycle

  task automatic spin_wait();
    repeat (SPIN_CYCLES) @(posedge clock_in);
  endtask : spin_wait

  task automatic rate_settle();
    repeat (SETTLE_CYCLES) @(posedge clock_in);
    cycle(2'd3, {8'h00, base_in, 2'h1}, 8'h03);
  endtask : rate_settle
endmodule : bodc_host

`default_nettype wire

/* File: testbench/tb_bodc_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_bodc_top;
  localparam logic [31:0] IDLE = 32'd200;  // Motor timeout shortened for simulation
  localparam logic [5:0]  BASE = 6'h2c;

  // ----------------------------------------
  // Design connections
  // ----------------------------------------
  logic        clock_in, reset_in, host_mem_rd_in, host_mem_wr_in, host_io_rd_in;
  logic        host_io_wr_in, phantom_n_out, host_rdata_oe_n_out, fdc_int_in, fdc_rd_out;
  logic        fdc_wr_out, fdc_status_rd_out, fdc_reset_out, fdc_clk_en_out, fdc_ready_out;
  logic        fdc_two_sided_out, drive_ready_in, drive_index_in, drive_two_sided_in;
  logic        motor_on_out, head_load_n_out, reduced_write_n_out, force_double_side_out;
  logic [15:0] host_addr_in;
  logic [7:0]  host_wdata_in, host_rdata_out, rom_data_in, fdc_wdata_out;
  logic [7:0]  fdc_status_in, fdc_rdata_in;
  logic [9:0]  board_config_switch_in;
  logic [5:0]  port_base_in;
  logic [3:0]  ready_substitute_jumpers_in;
  logic [10:0] rom_addr_out;
  logic [1:0]  fdc_unit_in;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          pulses;
  logic [7:0]  sel;
  logic [15:0] roma [3] = '{16'hfff0, 16'h0000, 16'h7ff1};
  logic [7:0]  offv [3] = '{8'h81, 8'h01, 8'h7f};
  int          rexp [4] = '{32, 16, 19, 9};  // 16x MFM rate counted over 4 us

  // ROM image: a pattern the bench can recompute from the address
  assign rom_data_in = rom_addr_out[7:0] ^ {5'h00, rom_addr_out[10:8]} ^ 8'ha5;

  bodc_top #(.MOTOR_IDLE_CYCLES(IDLE)) i_bodc_top (.*);
  bodc_host i_bodc_host
  (
    .clock_in      (clock_in),
    .base_in       (port_base_in),
    .phantom_n_in  (phantom_n_out),
    .rdata_in      (host_rdata_out),
    .rdata_oe_n_in (host_rdata_oe_n_out),
    .mem_rd_out    (host_mem_rd_in),
    .mem_wr_out    (host_mem_wr_in),
    .io_rd_out     (host_io_rd_in),
    .io_wr_out     (host_io_wr_in),
    .addr_out      (host_addr_in),
    .wdata_out     (host_wdata_in)
  );

  always #2 clock_in = ~clock_in;

  // Hang guard: the sequence needs about 10000 cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] ext(input logic x);
    return {7'h0, x};
  endfunction : ext

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_reset(input logic boot);
    reset_in = 1'b1;
    board_config_switch_in[8] = boot;
    repeat (5) @(posedge clock_in);
    #1 reset_in = 1'b0;
  endtask : do_reset

  task automatic io(input logic [1:0] k, input logic [1:0] p, input logic [7:0] d);
    i_bodc_host.cycle(k, {8'h00, BASE, p}, d);
  endtask : io

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    clock_in = 1'b0;
    board_config_switch_in = 10'h300;
    port_base_in = BASE;
    ready_substitute_jumpers_in = 4'h5;
    fdc_status_in = 8'h80;
    fdc_rdata_in = 8'h5c;
    fdc_int_in = 1'b1;
    fdc_unit_in = 2'h0;
    drive_ready_in = 1'b1;
    drive_index_in = 1'b0;
    drive_two_sided_in = 1'b0;
    do_reset(1'b1);
    foreach (roma[i])
    begin
      i_bodc_host.cycle(2'd0, roma[i], 8'h00);
      check("phantom", 8'h00, ext(i_bodc_host.ph));
      check("rom data", roma[i][7:0] ^ {5'h00, roma[i][10:8]} ^ 8'ha5, i_bodc_host.rd);
    end
    for (int k = 1; k < 4; k++)
    begin
      i_bodc_host.cycle(2'(k), {8'h00, BASE, 2'h1}, 8'h00);
      check("phantom idle", 8'h01, ext(i_bodc_host.ph));
      if (k == 2) check("ctrl data", 8'h5c, i_bodc_host.rd);
    end
    // Disable with bit 7 set, then try to re-enable with writes that leave bit 7 clear
    foreach (offv[i])
    begin
      io(2'd3, 2'h3, offv[i]);
      i_bodc_host.cycle(2'd0, 16'hfff0, 8'h00);
      check("phantom off", 8'h01, ext(i_bodc_host.ph));
      check("enable off", 8'h01, ext(i_bodc_host.oe_n));
    end
    do_reset(1'b0);
    i_bodc_host.cycle(2'd0, 16'hfff0, 8'h00);
    check("phantom no switch", 8'h01, ext(i_bodc_host.ph));
    do_reset(1'b1);
    i_bodc_host.cycle(2'd0, 16'hfff0, 8'h00);
    check("phantom reset", 8'h00, ext(i_bodc_host.ph));
    $display("test boot overlay done");
    io(2'd3, 2'h3, 8'h01);
    i_bodc_host.spin_wait();
    repeat (3)
    begin
      repeat (150) @(posedge clock_in);
      #1 check("motor held", 8'h01, ext(motor_on_out));
      io(2'd2, 2'h2, 8'h00);
      check("drive status", 8'h81, i_bodc_host.rd);
    end
    // Access lands on the very edge the timeout would fire
    repeat (IDLE - 2) @(posedge clock_in);
    io(2'd2, 2'h2, 8'h00);
    check("motor late access", 8'h01, ext(motor_on_out));
    repeat (IDLE + 2) @(posedge clock_in);
    #1 check("motor timeout", 8'h00, ext(motor_on_out));
    $display("test motor timer done");
    drive_ready_in = 1'b0;
    for (int j = 0; j < 8; j++)
    begin
      @(posedge clock_in) #1;
      ready_substitute_jumpers_in = 4'h5 << j[2];
      fdc_unit_in = j[1:0];
      #1 check("ready", ext(ready_substitute_jumpers_in[j[1:0]]), ext(fdc_ready_out));
    end
    for (int f = 1; f >= 0; f--)
    begin
      io(2'd3, 2'h0, f[0] ? 8'h88 : 8'h14);
      check("two sided", ext(f[0]), ext(fdc_two_sided_out));
      sel = {4'h0, fdc_reset_out, reduced_write_n_out, head_load_n_out, force_double_side_out};
      check("select lines", f[0] ? 8'h09 : 8'h06, sel);
    end
    drive_two_sided_in = 1'b1;
    #1 check("two sided drive", 8'h01, ext(fdc_two_sided_out));
    $display("test drive lines done");
    for (int c = 0; c < 4; c++)
    begin
      io(2'd3, 2'h0, {1'b0, c[1:0], 5'h14});
      i_bodc_host.rate_settle();
      pulses = 0;
      repeat (1000) @(posedge clock_in) #1 pulses += fdc_clk_en_out;
      check("clock rate", 8'h01, ext(pulses >= rexp[c] - 1 && pulses <= rexp[c] + 1));
    end
    $display("test data rate done");
    report_and_stop();
  end
endmodule : tb_bodc_top

bind bodc_top bodc_chk
  #(.MOTOR_IDLE_CYCLES(MOTOR_IDLE_CYCLES), .DRIVES(DRIVES)) i_bodc_chk (.*);

`default_nettype wire
